// ### core/scu_channel.sv
// Serial channel: shift mode and asynchronous modes behind Wishbone
module scu_channel #(
  parameter int TAP_N = 4
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire scu_pkg::scu_wb_req_t wb_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic [TAP_N-1:0]  prescaler_tap_i,
  input  wire logic              prescaler_run_i,
  input  wire logic              timer_match_i,
  input  wire logic              serial_in_pin_i,
  output logic                   serial_out_pin_o,
  input  wire logic              shift_clock_pin_i,
  output logic                   shift_clock_pin_o,
  output logic                   shift_clock_pin_oe_o,
  output logic                   transmit_irq_flag_o,
  output logic                   receive_irq_flag_o
);

  initial begin
    if (TAP_N != 4) $error("TAP_N must be 4");
  end

  // ********************
  // Functions and state
  // ********************
  function automatic logic [3:0] data_bits(input logic [1:0] fm);
    data_bits = (fm == scu_pkg::FM_UART7) ? 4'h7 : 4'h8;
  endfunction
  function automatic logic has_extra(input logic [1:0] fm,
                                     input logic pe);
    // Nine-bit frames carry the ninth bit, never parity
    has_extra = (fm == scu_pkg::FM_UART9) || pe;
  endfunction
  function automatic logic par_of(input logic [7:0] d,
                                  input logic [3:0] n,
                                  input logic even);
    logic [7:0] m;
    m = (n == 4'h7) ? {1'b0, d[6:0]} : d;
    par_of = even ? ^m : ~^m;
  endfunction
  logic [7:0]  serial_mode_reg, serial_control_reg, rx_buf, tx_buf;
  logic [5:0]  rate_generator_control;
  logic        tx_full, acc, wr, rd, brg_tick, sys_half;
  logic        sclk_prev, sclk_rise, src_tick, io_tick;
  logic [1:0]  frame_mode_field;
  logic        is_shift, parity_enable, receive_enable;
  logic        wakeup_filter_enable, ex;
  logic [3:0]  dn;
  logic        io_busy, io_phase, io_tx, io_rx, io_start, io_done;
  logic        rx_arm;
  logic [2:0]  io_cnt;
  logic [7:0]  io_tsh, io_rsh;
  scu_pkg::scu_tx_t tx_st;
  logic [11:0] tx_sh;
  logic [3:0]  tx_left, tx_ovs;
  logic        u_txd, u_start, u_tx_done;
  scu_pkg::scu_rx_t rx_st;
  logic [3:0]  rx_ovs, rx_idx;
  logic [9:0]  rx_sh;
  logic [1:0]  rx_smp;
  logic        rx_bit, rx_end, rx_take, rx_ovr, rx_parity_error_flag, rx_framing_error_flag;
  logic [7:0]  rx_data;
  logic        rx_extra, rx_keep;
  assign frame_mode_field     = serial_mode_reg[scu_pkg::MODE_FM +: 2];
  assign is_shift = frame_mode_field == scu_pkg::FM_SHIFT;
  assign receive_enable       = serial_mode_reg[scu_pkg::MODE_RXE];
  assign wakeup_filter_enable = serial_mode_reg[scu_pkg::MODE_WU];
  assign parity_enable = serial_control_reg[scu_pkg::CTRL_PE]
                         && frame_mode_field != scu_pkg::FM_UART9;
  assign dn = data_bits(frame_mode_field);
  assign ex = has_extra(frame_mode_field, parity_enable);
  // ********************
  // Bus slave
  // ********************
  // Effects fire on the edge that raises ack, once per request
  assign acc = wb_i.cyc && wb_i.stb && !wb_ack_o;
  assign wr  = acc && wb_i.we && wb_i.sel[0];
  assign rd  = acc && !wb_i.we;
  // Acknowledge and read data; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= '0;
      if (rd) begin
        case (wb_i.adr)
          scu_pkg::ADR_BUF:  wb_dat_o[7:0] <= rx_buf;
          scu_pkg::ADR_MODE: wb_dat_o[7:0] <= serial_mode_reg;
          scu_pkg::ADR_CTRL: wb_dat_o[7:0] <= serial_control_reg;
          scu_pkg::ADR_RATE: wb_dat_o[5:0] <= rate_generator_control;
          scu_pkg::ADR_IRQ:  wb_dat_o[2:0] <= {tx_full, receive_irq_flag_o,
                                               transmit_irq_flag_o};
          default:           wb_dat_o <= '0;
        endcase
      end
    end
  end
  // Mode and rate registers, written by software only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_mode_reg        <= scu_pkg::MODE_RST;
      rate_generator_control <= scu_pkg::RATE_RST;
    end else if (wr) begin
      if (wb_i.adr == scu_pkg::ADR_MODE) serial_mode_reg <= wb_i.dat[7:0];
      if (wb_i.adr == scu_pkg::ADR_RATE)
        rate_generator_control <= wb_i.dat[5:0];
    end
  end
  // Control register: hardware error and ninth-bit fields
  // Error set beats the read-clear so no event is lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_control_reg <= scu_pkg::CTRL_RST;
    end else begin
      if (wr && wb_i.adr == scu_pkg::ADR_CTRL) begin
        serial_control_reg[scu_pkg::CTRL_EVN] <= wb_i.dat[6];
        serial_control_reg[scu_pkg::CTRL_PE]  <= wb_i.dat[5];
        serial_control_reg[scu_pkg::CTRL_IOC] <= wb_i.dat[0];
      end
      if (rd && wb_i.adr == scu_pkg::ADR_CTRL) begin
        serial_control_reg[scu_pkg::CTRL_OE]  <= 1'b0;
        serial_control_reg[scu_pkg::CTRL_PER] <= 1'b0;
        serial_control_reg[scu_pkg::CTRL_FE]  <= 1'b0;
      end
      if (rx_end && rx_ovr)  serial_control_reg[scu_pkg::CTRL_OE] <= 1'b1;
      if (rx_end && rx_parity_error_flag) serial_control_reg[scu_pkg::CTRL_PER] <= 1'b1;
      if (rx_end && rx_framing_error_flag) serial_control_reg[scu_pkg::CTRL_FE] <= 1'b1;
      if (rx_take && ex)
        serial_control_reg[scu_pkg::CTRL_RB8] <= rx_extra;
    end
  end
  // ********************
  // Clock sources
  // ********************
  scu_rate_div #(
    .DIV_W (4)
  ) u_rate (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tap_i  (prescaler_run_i ? prescaler_tap_i : 4'h0),
    .sel_i  (rate_generator_control[scu_pkg::RATE_SEL +: 2]),
    .div_i  (rate_generator_control[scu_pkg::RATE_DIV +: 4]),
    .tick_o (brg_tick)
  );
  // Half system clock and external clock edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_half  <= 1'b0;
      sclk_prev <= 1'b1;
    end else begin
      sys_half  <= ~sys_half;
      sclk_prev <= shift_clock_pin_i;
    end
  end
  assign sclk_rise = shift_clock_pin_i && !sclk_prev;
  // Oversampling source for asynchronous modes, sixteen per bit
  always_comb begin
    case (serial_mode_reg[scu_pkg::MODE_CS +: 2])
      scu_pkg::CS_TIMER: src_tick = timer_match_i;
      scu_pkg::CS_RATE:  src_tick = brg_tick;
      scu_pkg::CS_SYS:   src_tick = sys_half;
      scu_pkg::CS_EXT:   src_tick = sclk_rise;
      default:           src_tick = 1'b0;
    endcase
  end
  // Shift mode: two ticks per bit halve the source rate
  assign io_tick = serial_control_reg[scu_pkg::CTRL_IOC] ? sclk_rise
                                                         : brg_tick;
  // ********************
  // Shift mode engine
  // ********************
  // Receive only after the previous byte was read
  assign rx_arm   = receive_enable && !receive_irq_flag_o;
  assign io_start = is_shift && !io_busy && (tx_full || rx_arm);
  assign io_done  = io_busy && io_tick && io_phase
                    && io_cnt == scu_pkg::SH_LAST;
  // Bits move only on supplied ticks, so an idle clock stalls it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_busy  <= 1'b0;
      io_phase <= 1'b0;
      io_cnt   <= '0;
      io_tx    <= 1'b0;
      io_rx    <= 1'b0;
      io_tsh   <= '0;
      io_rsh   <= '0;
    end else if (io_start) begin
      io_busy  <= 1'b1;
      io_phase <= 1'b0;
      io_cnt   <= '0;
      io_tx    <= tx_full;
      io_rx    <= rx_arm;
      io_tsh   <= tx_buf;
    end else if (io_busy && io_tick) begin
      io_phase <= ~io_phase;
      if (io_phase) begin
        io_rsh <= {serial_in_pin_i, io_rsh[7:1]};
        io_tsh <= {1'b1, io_tsh[7:1]};
        io_cnt <= io_cnt + 3'h1;
        if (io_cnt == scu_pkg::SH_LAST) io_busy <= 1'b0;
      end
    end
  end
  // Shift clock pin; stays high whenever it is not ours to drive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_clock_pin_o    <= 1'b1;
      shift_clock_pin_oe_o <= 1'b0;
    end else begin
      shift_clock_pin_o    <= !(io_busy && io_phase && is_shift
                                && !serial_control_reg[scu_pkg::CTRL_IOC]);
      shift_clock_pin_oe_o <= is_shift
                              && !serial_control_reg[scu_pkg::CTRL_IOC];
    end
  end
  // ********************
  // Transmit buffer and asynchronous transmitter
  // ********************
  assign u_start   = !is_shift && tx_st == scu_pkg::TX_IDLE && tx_full;
  assign u_tx_done = tx_st == scu_pkg::TX_SHIFT && src_tick
                     && tx_ovs == scu_pkg::OVS_LAST && tx_left == 4'h1;
  // A new write replaces a byte not yet taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_buf  <= '0;
      tx_full <= 1'b0;
    end else if (wr && wb_i.adr == scu_pkg::ADR_BUF) begin
      tx_buf  <= wb_i.dat[7:0];
      tx_full <= 1'b1;
    end else if ((io_start && tx_full) || u_start) begin
      tx_full <= 1'b0;
    end
  end
  // Frame out LSB first: start, data, ninth or parity, stop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_st   <= scu_pkg::TX_IDLE;
      tx_sh   <= '1;
      tx_left <= '0;
      tx_ovs  <= '0;
    end else begin
      case (tx_st)
        scu_pkg::TX_IDLE: begin
          if (u_start) begin
            tx_sh <= '1;
            tx_sh[0] <= 1'b0;
            for (int i = 0; i < 8; i++) begin
              if (4'(i) < dn) tx_sh[i+1] <= tx_buf[i];
            end
            if (frame_mode_field == scu_pkg::FM_UART9)
              tx_sh[9] <= serial_mode_reg[scu_pkg::MODE_TB8];
            else if (parity_enable)
              tx_sh[dn+4'h1] <= par_of(tx_buf, dn,
                serial_control_reg[scu_pkg::CTRL_EVN]);
            tx_left <= dn + 4'h2 + {3'h0, ex};
            tx_ovs  <= '0;
            tx_st   <= scu_pkg::TX_SHIFT;
          end
        end
        scu_pkg::TX_SHIFT: begin
          if (src_tick) begin
            tx_ovs <= tx_ovs + 4'h1;
            if (tx_ovs == scu_pkg::OVS_LAST) begin
              tx_sh   <= {1'b1, tx_sh[11:1]};
              tx_left <= tx_left - 4'h1;
              if (tx_left == 4'h1) tx_st <= scu_pkg::TX_IDLE;
            end
          end
        end
        default: tx_st <= scu_pkg::TX_IDLE;
      endcase
    end
  end
  assign u_txd = tx_st == scu_pkg::TX_SHIFT ? tx_sh[0] : 1'b1;
  // Output pin from one flop for both modes
  always_ff @(posedge clk_i) begin
    if (rst_i) serial_out_pin_o <= 1'b1;
    else if (is_shift) serial_out_pin_o <= io_busy && io_tx ? io_tsh[0]
                                                              : 1'b1;
    else serial_out_pin_o <= u_txd;
  end
  // ********************
  // Asynchronous receiver
  // ********************
  // Majority of three samples around the bit centre
  assign rx_bit = (rx_smp[0] & rx_smp[1]) | (rx_smp[0] & serial_in_pin_i)
                  | (rx_smp[1] & serial_in_pin_i);
  assign rx_end = rx_st == scu_pkg::RX_BITS && src_tick
                  && rx_ovs == scu_pkg::SMP_C
                  && rx_idx == dn + 4'h1 + {3'h0, ex};
  assign rx_data  = (dn == 4'h7) ? {1'b0, rx_sh[6:0]} : rx_sh[7:0];
  assign rx_extra = rx_sh[dn];
  assign rx_framing_error_flag  = !rx_bit;
  assign rx_parity_error_flag  = parity_enable
                    && rx_extra != par_of(rx_data, dn,
                       serial_control_reg[scu_pkg::CTRL_EVN]);
  // Wake-up filter drops data frames with ninth bit clear
  assign rx_keep  = !(frame_mode_field == scu_pkg::FM_UART9
                      && wakeup_filter_enable && !rx_extra);
  assign rx_take  = rx_end && !receive_irq_flag_o && rx_keep;
  assign rx_ovr   = rx_end && receive_irq_flag_o && rx_keep;
  // Receive state machine, three samples per bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_st  <= scu_pkg::RX_IDLE;
      rx_ovs <= '0;
      rx_idx <= '0;
      rx_sh  <= '0;
      rx_smp <= '0;
    end else begin
      case (rx_st)
        scu_pkg::RX_IDLE: begin
          rx_ovs <= '0;
          rx_idx <= '0;
          if (!is_shift && receive_enable && src_tick && !serial_in_pin_i)
            rx_st <= scu_pkg::RX_BITS;
        end
        scu_pkg::RX_BITS: begin
          if (src_tick) begin
            rx_ovs <= rx_ovs + 4'h1;
            if (rx_ovs == scu_pkg::SMP_A) rx_smp[0] <= serial_in_pin_i;
            if (rx_ovs == scu_pkg::SMP_B) rx_smp[1] <= serial_in_pin_i;
            if (rx_ovs == scu_pkg::SMP_C) begin
              rx_idx <= rx_idx + 4'h1;
              if (rx_idx == 4'h0 && rx_bit) rx_st <= scu_pkg::RX_IDLE;
              else if (rx_idx != 4'h0) rx_sh[rx_idx - 4'h1] <= rx_bit;
              if (rx_end) rx_st <= scu_pkg::RX_IDLE;
            end
          end
          if (is_shift) rx_st <= scu_pkg::RX_IDLE;
        end
        default: rx_st <= scu_pkg::RX_IDLE;
      endcase
    end
  end
  // Receive buffer, loaded at the end of either engine
  always_ff @(posedge clk_i) begin
    if (rst_i) rx_buf <= '0;
    else if (io_done && io_rx) rx_buf <= io_rsh[7:0] >> 1
                                         | {serial_in_pin_i, 7'h00};
    else if (rx_take) rx_buf <= rx_data;
  end
  // Set beats clear; buffer read clears receive, write-one clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      transmit_irq_flag_o <= 1'b0;
      receive_irq_flag_o  <= 1'b0;
    end else begin
      if (wr && wb_i.adr == scu_pkg::ADR_IRQ && wb_i.dat[scu_pkg::IRQ_TX])
        transmit_irq_flag_o <= 1'b0;
      if ((wr && wb_i.adr == scu_pkg::ADR_IRQ && wb_i.dat[scu_pkg::IRQ_RX])
          || (rd && wb_i.adr == scu_pkg::ADR_BUF))
        receive_irq_flag_o <= 1'b0;
      if ((io_done && io_tx) || u_tx_done)
        transmit_irq_flag_o <= 1'b1;
      if ((io_done && io_rx) || rx_take)
        receive_irq_flag_o <= 1'b1;
    end
  end

endmodule

// ### common/scu_pkg.sv
// Constants, types and register map of the serial channel
//
// Function
// - Two-bit field picks prescaler tap
// - Four-bit divider divides tap by 1..16
// - Shift mode rate: generator output halved
// - Asynchronous modes divide source by sixteen
// - Timer match source, async only, over 16
// - External clock: half in shift, sixteenth async
// - Clock-out shift mode: write sends eight bits
// - Clock-in shift mode: send on supplied clocks
// - Clock-out: buffer read starts next receive
// - Clock-in: receive after read, external clocks
// - Mode 01/10/11 give 7/8/9-bit frames
// - Parity enable and even/odd select
// - No parity in nine-bit mode
// - Ninth transmit bit from mode register
// - Ninth received bit into control register
// - Wake-up: ninth bit one raises receive
// - Rate taps come from shared prescaler
// - Wake-up: ninth bit zero raises no receive flag or overrun
// - Control register read clears error flags
// - Transmit least significant bit first
package scu_pkg;

  // ********************
  // Register offsets
  // ********************
  localparam logic [7:0] ADR_BUF  = 8'h00;
  localparam logic [7:0] ADR_MODE = 8'h04;
  localparam logic [7:0] ADR_CTRL = 8'h08;
  localparam logic [7:0] ADR_RATE = 8'h0c;
  localparam logic [7:0] ADR_IRQ  = 8'h10;

  // ********************
  // Field positions
  // ********************
  localparam int MODE_TB8 = 7;
  localparam int MODE_RXE = 5;
  localparam int MODE_WU  = 4;
  localparam int MODE_FM  = 2;
  localparam int MODE_CS  = 0;
  localparam int CTRL_RB8 = 7;
  localparam int CTRL_EVN = 6;
  localparam int CTRL_PE  = 5;
  localparam int CTRL_OE  = 4;
  localparam int CTRL_PER = 3;
  localparam int CTRL_FE  = 2;
  localparam int CTRL_IOC = 0;
  localparam int RATE_SEL = 4;
  localparam int RATE_DIV = 0;
  localparam int IRQ_TX   = 0;
  localparam int IRQ_RX   = 1;
  localparam int IRQ_BSY  = 2;

  // ********************
  // Reset values and counts
  // ********************
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [5:0] RATE_RST = 6'h00;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] SMP_A    = 4'h7;
  localparam logic [3:0] SMP_B    = 4'h8;
  localparam logic [3:0] SMP_C    = 4'h9;
  localparam logic [2:0] SH_LAST  = 3'h7;

  typedef enum logic [1:0] {
    FM_SHIFT = 2'b00,
    FM_UART7 = 2'b01,
    FM_UART8 = 2'b10,
    FM_UART9 = 2'b11
  } scu_frame_t;

  typedef enum logic [1:0] {
    CS_TIMER = 2'b00,
    CS_RATE  = 2'b01,
    CS_SYS   = 2'b10,
    CS_EXT   = 2'b11
  } scu_csel_t;

  typedef enum logic [0:0] {
    TX_IDLE  = 1'b0,
    TX_SHIFT = 1'b1
  } scu_tx_t;

  typedef enum logic [0:0] {
    RX_IDLE = 1'b0,
    RX_BITS = 1'b1
  } scu_rx_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } scu_wb_req_t;

endpackage

// ### core/scu_rate_div.sv
// Rate generator: prescaler tap select and programmable divider
module scu_rate_div #(
  parameter int DIV_W = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [3:0]       tap_i,
  input  wire logic [1:0]       sel_i,
  input  wire logic [DIV_W-1:0] div_i,
  output logic                  tick_o
);

  logic [DIV_W-1:0] cnt;
  logic             tap;

  initial begin
    if (DIV_W < 1 || DIV_W > 8) $error("DIV_W out of range");
  end

  // Tap picked from the shared prescaler
  assign tap = tap_i[sel_i];

  // Divide by div; zero field means the full range of 16
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (tap) begin
        if (cnt == div_i - DIV_W'(1)) begin
          cnt    <= '0;
          tick_o <= 1'b1;
        end else begin
          cnt <= cnt + DIV_W'(1);
        end
      end
    end
  end

endmodule

// ### verification/scu_channel_props.sv
// Checker of bus handshake and pin behaviour of the serial channel
module scu_channel_chk (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire scu_pkg::scu_wb_req_t wb_i,
  input  wire logic [31:0]          wb_dat_o,
  input  wire logic                 wb_ack_o,
  input  wire logic                 prescaler_run_i,
  input  wire logic                 shift_clock_pin_o,
  input  wire logic                 shift_clock_pin_oe_o,
  input  wire logic                 transmit_irq_flag_o,
  input  wire logic                 receive_irq_flag_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic irq_wr;
  logic buf_rd;

  // Decoded requests that may clear the sticky flags
  assign irq_wr = wb_i.cyc && wb_i.stb && wb_i.we
                  && wb_i.adr == scu_pkg::ADR_IRQ;
  assign buf_rd = wb_i.cyc && wb_i.stb && !wb_i.we
                  && wb_i.adr == scu_pkg::ADR_BUF;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ********************
  // Sequences
  // ********************
  sequence s_req;
    wb_i.cyc && wb_i.stb && !wb_ack_o;
  endsequence
  // Stopped prescaler seen on two edges while the pin is ours
  sequence s_halt;
    (!prescaler_run_i && shift_clock_pin_oe_o) [*2];
  endsequence

  chk_ack_next: assert property (s_req |=> wb_ack_o)
    else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_i.cyc && wb_i.stb))
    else $error("ack without request");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data outside ack");
  chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper data set");
  chk_halt_norun: assert property (s_halt |-> $stable(shift_clock_pin_o))
    else $error("clock moved, no prescaler");
  chk_tx_clear: assert property ($fell(transmit_irq_flag_o) |-> $past(irq_wr))
    else $error("tx flag cleared alone");
  chk_rx_clear: assert property ($fell(receive_irq_flag_o) |-> $past(buf_rd || irq_wr))
    else $error("rx flag cleared alone");
  chk_sclk_idle: assert property (!shift_clock_pin_oe_o |-> shift_clock_pin_o)
    else $error("clock low undriven");
endmodule

bind scu_channel scu_channel_chk u_chk (
  .clk_i, .rst_i, .wb_i, .wb_dat_o, .wb_ack_o, .prescaler_run_i,
  .shift_clock_pin_o, .shift_clock_pin_oe_o, .transmit_irq_flag_o,
  .receive_irq_flag_o);

// ### verification/scu_far_end.sv
// Far-end model: shift partner, clock source, echo station
module scu_far_end (
  input  wire logic       clk_i,
  input  wire logic       loop_i,
  input  wire logic       ext_en_i,
  input  wire logic       load_i,
  input  wire logic [7:0] pat_i,
  input  wire logic       sout_i,
  input  wire logic       sclk_i,
  input  wire logic       sclk_oe_i,
  output logic            sin_o,
  output logic            sclk_o,
  output logic [7:0]      cap_o,
  output int              per_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       ext = 1'b1;
  logic       prev = 1'b1;
  logic       drv = 1'b1;
  logic [7:0] sh = 8'h00;
  int         ediv = 0;
  int         cnt = 0;

  // Wire level: block drives when enabled, else our clock
  assign sclk_o = sclk_oe_i ? sclk_i : ext;
  // Async station echoes frames
  assign sin_o = loop_i ? sout_i : drv;

  // External clock idles high
  always @(posedge clk_i) begin
    if (!ext_en_i) begin
      ext <= 1'b1;
      ediv <= 0;
    end else if (ediv == 4) begin
      ext <= ~ext;
      ediv <= 0;
    end else begin
      ediv <= ediv + 1;
    end
  end

  // Data changes on the fall, settled at the rise
  always @(posedge clk_i) begin
    prev <= sclk_o;
    cnt <= (sclk_o && !prev) ? 0 : cnt + 1;
    if (sclk_o && !prev)
      per_o <= cnt + 1;
    if (load_i)
      sh <= pat_i;
    else if (!sclk_o && prev) begin
      drv <= sh[0];
      sh <= {~sh[0], sh[7:1]};  // Spent line keeps toggling
      cap_o <= {sout_i, cap_o[7:1]};
    end
  end
endmodule

// ### verification/serial_channel_uart_sync_bench.sv
// Self-checking bench of the serial channel with its far-end model
module serial_channel_uart_sync_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] RATES [3] = '{8'h02, 8'h10, 8'h25};
  localparam logic [7:0] MODES [5] = '{8'h2a, 8'h29, 8'h24, 8'hbe, 8'h3e};
  localparam logic [7:0] CTRLS [5] = '{8'h60, 8'h20, 8'h00, 8'h60, 8'h60};
  logic                 clk_i;
  logic                 rst_i;
  scu_pkg::scu_wb_req_t wb;
  logic [31:0]          wb_dat_o;
  logic                 wb_ack_o;
  logic [3:0]           tap;
  logic                 run;
  logic                 sin;
  logic                 sout;
  logic                 sclk;
  logic                 sclk_o;
  logic                 sclk_oe;
  logic                 tx_flag;
  logic                 rx_flag;
  logic                 loop;
  logic                 ext_en;
  logic                 load;
  logic [7:0]           pat;
  logic [7:0]           cap;
  int                   per;
  int                   cycles = 0;
  int                   failures = 0;
  int                   n_compared = 0;
  logic [7:0]           exp_q[$];

  // Shared prescaler taps at fc/4, fc/16, fc/64, fc/256
  assign tap = {cycles[7:0] == 8'h0, cycles[5:0] == 6'h0,
                cycles[3:0] == 4'h0, cycles[1:0] == 2'h0};

  scu_channel dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .prescaler_tap_i(tap), .prescaler_run_i(run),
    .timer_match_i(tap[1]), .serial_in_pin_i(sin), .serial_out_pin_o(sout),
    .shift_clock_pin_i(sclk), .shift_clock_pin_o(sclk_o),
    .shift_clock_pin_oe_o(sclk_oe), .transmit_irq_flag_o(tx_flag),
    .receive_irq_flag_o(rx_flag));

  scu_far_end far (
    .clk_i(clk_i), .loop_i(loop), .ext_en_i(ext_en), .load_i(load),
    .pat_i(pat), .sout_i(sout), .sclk_i(sclk_o), .sclk_oe_i(sclk_oe),
    .sin_o(sin), .sclk_o(sclk), .cap_o(cap), .per_o(per));

  // ********************
  // Tasks and model
  // ********************
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] got,
                       input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Hold request until ack, then idle a cycle
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    wb <= '{1'b1, 1'b1, we, a, 4'h1, {24'h0, d}};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb <= '0;
    @(posedge clk_i);
  endtask

  task automatic wait_flag(input logic rx);
    while ((rx ? rx_flag : tx_flag) !== 1'b1)
      @(posedge clk_i);
  endtask

  task automatic arm(input logic [7:0] v);
    pat <= v;
    load <= 1'b1;
    @(posedge clk_i);
    load <= 1'b0;
  endtask

  // Rise-to-rise: two ticks per bit
  function automatic int bit_per(input logic [7:0] r);
    return 2 * (4 << (2 * r[5:4])) * (r[3:0] == 4'h0 ? 16 : int'(r[3:0]));
  endfunction

  function automatic logic exp_ninth(input logic [7:0] md, ct, d);
    if (md[3:2] == 2'b11)
      return md[7];
    return ct[6] ? ^d : ~^d;
  endfunction

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    logic [7:0] q;
    logic [7:0] b;
    logic [7:0] m;
    rst_i = 1'b1;
    wb = '0;
    run = 1'b0;
    loop = 1'b0;
    ext_en = 1'b0;
    load = 1'b0;
    pat = 8'h00;
    void'($urandom(32'h6dbe69c4));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Reset values, read-only bits, map hole
    bus(1'b0, scu_pkg::ADR_MODE, 8'h00, q);
    check("mode reset", 16'(q), 16'(scu_pkg::MODE_RST));
    bus(1'b0, scu_pkg::ADR_RATE, 8'h00, q);
    check("rate reset", 16'(q), 16'(scu_pkg::RATE_RST));
    bus(1'b1, 8'h14, 8'hff, q);
    bus(1'b0, 8'h14, 8'h00, q);
    check("hole", 16'(q), 16'h0);
    bus(1'b1, scu_pkg::ADR_CTRL, 8'hff, q);
    bus(1'b0, scu_pkg::ADR_CTRL, 8'h00, q);
    check("ctrl rw", 16'(q & 8'hfd), 16'h61);
    bus(1'b1, scu_pkg::ADR_CTRL, 8'h00, q);
    $display("registers done");
    // Clock-out send; first waits for prescaler
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, scu_pkg::ADR_RATE, RATES[i], q);
      b = 8'($urandom);
      exp_q.push_back(b);
      bus(1'b1, scu_pkg::ADR_BUF, b, q);
      repeat (200) @(posedge clk_i);
      if (i == 0) begin
        check("no run", 16'(tx_flag), 16'h0);
        run <= 1'b1;
      end
      wait_flag(1'b0);
      check("tx byte", 16'(cap), 16'(exp_q.pop_front()));
      check("period", 16'(per), 16'(bit_per(RATES[i])));
      bus(1'b1, scu_pkg::ADR_IRQ, 8'h03, q);
    end
    $display("shift send done");
    // Clock-out receive; a read starts the next
    bus(1'b1, scu_pkg::ADR_RATE, 8'h02, q);
    arm(8'($urandom));
    bus(1'b1, scu_pkg::ADR_MODE, 8'h20, q);
    for (int i = 0; i < 2; i++) begin
      wait_flag(1'b1);
      b = pat;
      if (i == 1)
        bus(1'b1, scu_pkg::ADR_MODE, 8'h00, q);
      else
        arm(8'($urandom));
      bus(1'b0, scu_pkg::ADR_BUF, 8'h00, q);
      check("rx byte", 16'(q), 16'(b));
    end
    $display("shift receive done");
    // Clock-in send stalls until clocked
    bus(1'b1, scu_pkg::ADR_CTRL, 8'h01, q);
    bus(1'b1, scu_pkg::ADR_BUF, 8'($urandom), q);
    repeat (100) @(posedge clk_i);
    check("no clock", 16'(tx_flag), 16'h0);
    ext_en <= 1'b1;
    wait_flag(1'b0);
    ext_en <= 1'b0;
    check("clocked", 16'(tx_flag), 16'h1);
    bus(1'b1, scu_pkg::ADR_IRQ, 8'h03, q);
    $display("clock-in done");
    // Async formats through the echoing station
    loop <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, scu_pkg::ADR_CTRL, CTRLS[i], q);
      bus(1'b1, scu_pkg::ADR_MODE, MODES[i], q);
      b = 8'($urandom);
      b[0] = b[0] ^ (^b);  // Even weight, so a stray parity bit shows
      m = (MODES[i][3:2] == 2'b01) ? 8'h7f : 8'hff;
      bus(1'b1, scu_pkg::ADR_BUF, b, q);
      wait_flag(1'b0);
      repeat (40) @(posedge clk_i);
      check("rx flag", 16'(rx_flag), 16'(i != 4));
      bus(1'b0, scu_pkg::ADR_CTRL, 8'h00, q);
      check("errors", 16'(q & 8'h1c), 16'h0);
      if (i != 2 && i != 4)
        check("ninth", 16'(q[7]), 16'(exp_ninth(MODES[i], CTRLS[i], b)));
      bus(1'b0, scu_pkg::ADR_BUF, 8'h00, q);
      if (i != 4)
        check("rx data", 16'(q & m), 16'(b & m));
      bus(1'b1, scu_pkg::ADR_IRQ, 8'h03, q);
    end
    $display("async done");
    close_out();
  end
endmodule
